// ---- eth_mac_ptp_timestamp.sv ----
// MAC register map over APB with time-stamping timer, event flags and interrupt
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eth_mac_ptp_timestamp
   import eth_ptp_pkg::*;
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [eth_ptp_pkg::ADDR_W-1:0] paddr,
   input  wire logic [eth_ptp_pkg::DATA_W-1:0] pwdata,
   output logic      [eth_ptp_pkg::DATA_W-1:0] prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic                           tx_frame_done,
   input  wire logic                           tx_stamp_request,
   input  wire logic [eth_ptp_pkg::STAT_W-2:0] tx_frame_status,
   output logic      [eth_ptp_pkg::DATA_W-1:0] tx_stamp_value,
   output logic      [eth_ptp_pkg::SEQ_W-1:0]  tx_stamp_sequence,
   output logic      [eth_ptp_pkg::STAT_W-1:0] tx_stamp_status,
   output logic                                tx_stamp_valid,
   input  wire logic                           rx_sfd_detect,
   input  wire logic                           rx_frame_end,
   output logic      [eth_ptp_pkg::DATA_W-1:0] rx_stamp_value,
   output logic                                rx_desc_stamp_write,
   input  wire logic [eth_ptp_pkg::DATA_W-1:0] mac_event_set,
   output logic                                irq
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } bus_state_e;

   bus_state_e        state_reg;
   bus_state_e        state_next;
   logic [DATA_W-1:0] prdata_next;
   logic              pready_next;
   logic              pslverr_next;
   logic              wr_fire;
   logic              rd_hit;
   logic [DATA_W-1:0] rd_data;

   logic [DATA_W-1:0] rw_reg  [N_RW];
   logic [DATA_W-1:0] rw_next [N_RW];
   logic [DATA_W-1:0] control_reg;
   logic [DATA_W-1:0] control_next;
   logic [DATA_W-1:0] event_flags_reg;
   logic [DATA_W-1:0] event_flags_next;
   logic [DATA_W-1:0] event_mask_reg;
   logic [DATA_W-1:0] event_mask_next;
   logic [DATA_W-1:0] timer_reg;
   logic [DATA_W-1:0] timer_next;
   logic [DATA_W-1:0] timer_period_reg;
   logic [DATA_W-1:0] timer_period_next;
   logic              timer_wrap_reg;
   logic              timer_wrap_next;
   logic              irq_next;
   logic [DATA_W:0]   timer_sum;
   logic [DATA_W-1:0] flag_set;

   logic              stamp_enable;
   logic [DATA_W-1:0] tx_hold_value;
   logic              tx_hold_set;

   assign stamp_enable = control_reg[CTRL_STAMP_EN_BIT];

   // Write lands only at the edge where the master sees pready high
   assign wr_fire = psel && penable && pready && pwrite;

   // One wait state: read data is muxed in the first access cycle
   always_comb begin
      state_next   = state_reg;
      prdata_next  = prdata;
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (psel && penable) begin
               state_next   = ST_ACK;
               pready_next  = 1'b1;
               pslverr_next = !rd_hit;
               prdata_next  = (pwrite || !rd_hit) ? '0 : rd_data;
            end
         end
         ST_ACK: begin
            state_next = ST_IDLE;
         end
         // Two-bit one-hot leaves codes that must fall back to idle
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         prdata    <= '0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
      end else begin
         state_reg <= state_next;
         prdata    <= prdata_next;
         pready    <= pready_next;
         pslverr   <= pslverr_next;
      end
   end

   // Address decode and read mux; unmapped addresses answer with pslverr
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = '0;
      unique case (paddr)
         OFS_EVENT_FLAGS:   rd_data = event_flags_reg;
         OFS_EVENT_MASK:    rd_data = event_mask_reg;
         OFS_ETH_CONTROL:   rd_data = control_reg;
         OFS_RX_FIFO_BOUND: rd_data = RX_FIFO_BOUND_VALUE;
         OFS_TIMER_VALUE:   rd_data = timer_reg;
         OFS_TIMER_PERIOD:  rd_data = timer_period_reg;
         OFS_TX_STAMP_HOLD: rd_data = tx_hold_value;
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < N_RW; i++) begin
               if (paddr == RW_OFS[i]) begin
                  rd_hit  = 1'b1;
                  rd_data = rw_reg[i];
               end
            end
         end
      endcase
   end

   // Plain storage for the MAC words this block does not interpret
   genvar g;
   generate
      for (g = 0; g < N_RW; g++) begin : g_rw
         always_comb begin
            rw_next[g] = rw_reg[g];
            if (wr_fire && paddr == RW_OFS[g]) begin
               rw_next[g] = pwdata;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rw_reg[g] <= RW_RESET;
            end else begin
               rw_reg[g] <= rw_next[g];
            end
         end
      end
   endgenerate

   // Control, mask, period and event flags
   always_comb begin
      control_next      = control_reg;
      event_mask_next   = event_mask_reg;
      timer_period_next = timer_period_reg;
      flag_set          = mac_event_set;
      flag_set[FLAG_STAMP_READY_BIT] = tx_hold_set;
      flag_set[FLAG_TIMER_EVENT_BIT] = timer_wrap_reg;
      event_flags_next  = event_flags_reg;
      if (wr_fire && paddr == OFS_ETH_CONTROL) begin
         control_next = pwdata;
      end
      if (wr_fire && paddr == OFS_EVENT_MASK) begin
         event_mask_next = pwdata;
      end
      if (wr_fire && paddr == OFS_TIMER_PERIOD) begin
         timer_period_next = pwdata;
      end
      if (wr_fire && paddr == OFS_EVENT_FLAGS) begin
         event_flags_next = event_flags_reg & ~pwdata;
      end
      // Set beats a clear landing in the same cycle
      event_flags_next = event_flags_next | flag_set;
      irq_next = |(event_flags_reg & event_mask_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg      <= CONTROL_RESET;
         event_mask_reg   <= '0;
         timer_period_reg <= TIMER_PERIOD_RESET;
         event_flags_reg  <= '0;
         irq              <= 1'b0;
      end else begin
         control_reg      <= control_next;
         event_mask_reg   <= event_mask_next;
         timer_period_reg <= timer_period_next;
         event_flags_reg  <= event_flags_next;
         irq              <= irq_next;
      end
   end

   // Nanosecond timer; wraps at the programmed period and raises an event.
   // A period of zero is treated as free running so the timer never sticks.
   always_comb begin
      timer_sum       = {1'b0, timer_reg} + {1'b0, TIMER_INC};
      timer_next      = timer_reg;
      timer_wrap_next = 1'b0;
      if (stamp_enable) begin
         if (timer_period_reg != '0 && timer_sum >= {1'b0, timer_period_reg}) begin
            timer_next      = DATA_W'(timer_sum - {1'b0, timer_period_reg});
            timer_wrap_next = 1'b1;
         end else begin
            timer_next = timer_sum[DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg      <= '0;
         timer_wrap_reg <= 1'b0;
      end else begin
         timer_reg      <= timer_next;
         timer_wrap_reg <= timer_wrap_next;
      end
   end

   eth_ptp_tx_stamp u_tx_stamp (
      .pclk           (pclk),
      .presetn        (presetn),
      .stamp_enable   (stamp_enable),
      .timer_value    (timer_reg),
      .frame_done     (tx_frame_done),
      .stamp_request  (tx_stamp_request),
      .frame_status   (tx_frame_status),
      .stamp_value    (tx_stamp_value),
      .stamp_sequence (tx_stamp_sequence),
      .stamp_status   (tx_stamp_status),
      .stamp_valid    (tx_stamp_valid),
      .hold_value     (tx_hold_value),
      .hold_set       (tx_hold_set)
   );

   eth_ptp_rx_stamp u_rx_stamp (
      .pclk         (pclk),
      .presetn      (presetn),
      .stamp_enable (stamp_enable),
      .timer_value  (timer_reg),
      .sfd_detect   (rx_sfd_detect),
      .frame_end    (rx_frame_end),
      .stamp_value  (rx_stamp_value),
      .desc_write   (rx_desc_stamp_write)
   );

   property p_ready_flag;
      @(posedge pclk) disable iff (!presetn)
      tx_hold_set |=> event_flags_reg[FLAG_STAMP_READY_BIT];
   endproperty
   a_ready_flag: assert property (p_ready_flag) else $error("stamp_ready not set");

   property p_timer_flag;
      @(posedge pclk) disable iff (!presetn)
      timer_wrap_reg |=> event_flags_reg[FLAG_TIMER_EVENT_BIT];
   endproperty
   a_timer_flag: assert property (p_timer_flag) else $error("timer_event not set");

   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
      wr_fire && paddr == OFS_EVENT_FLAGS && pwdata[FLAG_STAMP_READY_BIT] && !tx_hold_set
      |=> !event_flags_reg[FLAG_STAMP_READY_BIT];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear");

   property p_flag_keep;
      @(posedge pclk) disable iff (!presetn)
      wr_fire && paddr == OFS_EVENT_FLAGS && !pwdata[FLAG_TIMER_EVENT_BIT]
      && event_flags_reg[FLAG_TIMER_EVENT_BIT] |=> event_flags_reg[FLAG_TIMER_EVENT_BIT];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("write zero cleared");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (|(event_flags_reg & event_mask_reg)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_irq_quiet;
      @(posedge pclk) disable iff (!presetn)
      !(|(event_flags_reg & event_mask_reg)) |=> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause");

   property p_timer_hold;
      @(posedge pclk) disable iff (!presetn)
      !stamp_enable |=> $stable(timer_reg);
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("timer ran disabled");
endmodule // eth_mac_ptp_timestamp
`default_nettype wire

// ---- eth_ptp_pkg.sv ----
// Constants, register map and field layout for the MAC time-stamping block
// Contract
// - Stamp only while stamp_enable is one
// - Return value, sequence and status per frame
// - Status bit 5 mirrors the request
// - Flagged frame loads hold, sets stamp_ready
// - Unflagged frames leave hold and flag alone
// - Latch timer at SFD, show it
// - Hand receive stamp to descriptor write
// - Stamp and timer events share MAC interrupt
// - Masked flags interrupt; W1C; reset clears
package eth_ptp_pkg;
   localparam int          ADDR_W                = 12;
   localparam int          DATA_W                = 32;
   localparam int          SEQ_W                 = 4;
   localparam int          STAT_W                = 6;
   localparam int          STAT_REQ_BIT          = 5;
   localparam int          CTRL_STAMP_EN_BIT     = 4;
   localparam int          FLAG_STAMP_READY_BIT  = 15;
   localparam int          FLAG_TIMER_EVENT_BIT  = 16;
   localparam logic [11:0] OFS_EVENT_FLAGS       = 12'h004;
   localparam logic [11:0] OFS_EVENT_MASK        = 12'h008;
   localparam logic [11:0] OFS_ETH_CONTROL       = 12'h024;
   localparam logic [11:0] OFS_RX_FIFO_BOUND     = 12'h14c;
   localparam logic [11:0] OFS_TIMER_VALUE       = 12'h400;
   localparam logic [11:0] OFS_TIMER_PERIOD      = 12'h404;
   localparam logic [11:0] OFS_TX_STAMP_HOLD     = 12'h408;
   localparam int          N_RW                  = 21;
   localparam logic [11:0] RW_OFS [N_RW] = '{
      12'h010, 12'h014, 12'h040, 12'h044, 12'h064, 12'h084, 12'h0c4,
      12'h0e4, 12'h0e8, 12'h0ec, 12'h118, 12'h11c, 12'h120, 12'h124,
      12'h144, 12'h150, 12'h180, 12'h184, 12'h188, 12'h300, 12'h308};
   localparam logic [31:0] RW_RESET              = 32'h0000_0000;
   localparam logic [31:0] CONTROL_RESET         = 32'h0000_0000;
   localparam logic [31:0] RX_FIFO_BOUND_VALUE   = 32'h0000_0600;
   localparam int          CLK_PERIOD_NS         = 20;
   localparam logic [31:0] TIMER_INC             = 32'(CLK_PERIOD_NS);
   localparam logic [31:0] TIMER_PERIOD_RESET    = 32'h3b9a_ca00;
endpackage

// ---- eth_ptp_rx_stamp.sv ----
// Receive timestamp latch at start frame delimiter and descriptor hand-off
`timescale 1ns/1ps
`default_nettype none
module eth_ptp_rx_stamp
   import eth_ptp_pkg::*;
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           stamp_enable,
   input  wire logic [eth_ptp_pkg::DATA_W-1:0] timer_value,
   input  wire logic                           sfd_detect,
   input  wire logic                           frame_end,
   output logic      [eth_ptp_pkg::DATA_W-1:0] stamp_value,
   output logic                                desc_write
);
   logic [DATA_W-1:0] value_next;
   logic              armed_reg;
   logic              armed_next;
   logic              write_next;

   always_comb begin
      value_next = stamp_value;
      armed_next = armed_reg;
      write_next = 1'b0;
      if (stamp_enable && sfd_detect) begin
         value_next = timer_value;
         armed_next = 1'b1;
      end else if (frame_end) begin
         write_next = armed_reg && stamp_enable;
         armed_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_value <= '0;
         armed_reg   <= 1'b0;
         desc_write  <= 1'b0;
      end else begin
         stamp_value <= value_next;
         armed_reg   <= armed_next;
         desc_write  <= write_next;
      end
   end

   property p_rx_latch;
      @(posedge pclk) disable iff (!presetn)
      sfd_detect && stamp_enable |=> stamp_value == $past(timer_value);
   endproperty
   a_rx_latch: assert property (p_rx_latch) else $error("rx stamp not latched");

   property p_rx_desc;
      @(posedge pclk) disable iff (!presetn)
      sfd_detect && stamp_enable ##1 (!sfd_detect && !frame_end)[*1] ##1
      (frame_end && !sfd_detect && stamp_enable) |=> desc_write;
   endproperty
   a_rx_desc: assert property (p_rx_desc) else $error("descriptor write missed");
endmodule // eth_ptp_rx_stamp
`default_nettype wire

// ---- eth_ptp_tx_stamp.sv ----
// Transmit timestamp return, sequence numbering and holding register
`timescale 1ns/1ps
`default_nettype none
module eth_ptp_tx_stamp
   import eth_ptp_pkg::*;
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           stamp_enable,
   input  wire logic [eth_ptp_pkg::DATA_W-1:0] timer_value,
   input  wire logic                           frame_done,
   input  wire logic                           stamp_request,
   input  wire logic [eth_ptp_pkg::STAT_W-2:0] frame_status,
   output logic      [eth_ptp_pkg::DATA_W-1:0] stamp_value,
   output logic      [eth_ptp_pkg::SEQ_W-1:0]  stamp_sequence,
   output logic      [eth_ptp_pkg::STAT_W-1:0] stamp_status,
   output logic                                stamp_valid,
   output logic      [eth_ptp_pkg::DATA_W-1:0] hold_value,
   output logic                                hold_set
);
   logic [DATA_W-1:0] value_next;
   logic [SEQ_W-1:0]  seq_next;
   logic [STAT_W-1:0] status_next;
   logic              valid_next;
   logic [DATA_W-1:0] hold_next;
   logic              set_next;
   logic              take;

   always_comb begin
      take        = frame_done && stamp_enable;
      value_next  = stamp_value;
      seq_next    = stamp_sequence;
      status_next = stamp_status;
      valid_next  = take;
      hold_next   = hold_value;
      set_next    = 1'b0;
      if (take) begin
         value_next  = timer_value;
         seq_next    = SEQ_W'(stamp_sequence + 1'b1);
         status_next = {stamp_request, frame_status};
         if (stamp_request) begin
            hold_next = timer_value;
            set_next  = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_value    <= '0;
         stamp_sequence <= '0;
         stamp_status   <= '0;
         stamp_valid    <= 1'b0;
         hold_value     <= '0;
         hold_set       <= 1'b0;
      end else begin
         stamp_value    <= value_next;
         stamp_sequence <= seq_next;
         stamp_status   <= status_next;
         stamp_valid    <= valid_next;
         hold_value     <= hold_next;
         hold_set       <= set_next;
      end
   end

   property p_tx_disabled;
      @(posedge pclk) disable iff (!presetn)
      frame_done && !stamp_enable |=> !stamp_valid && !hold_set && $stable(hold_value);
   endproperty
   a_tx_disabled: assert property (p_tx_disabled) else $error("stamp while disabled");

   property p_tx_return;
      @(posedge pclk) disable iff (!presetn)
      frame_done && stamp_enable |=> stamp_valid && stamp_value == $past(timer_value);
   endproperty
   a_tx_return: assert property (p_tx_return) else $error("tx stamp not returned");

   property p_tx_status;
      @(posedge pclk) disable iff (!presetn)
      frame_done && stamp_enable |=> stamp_status[STAT_REQ_BIT] == $past(stamp_request);
   endproperty
   a_tx_status: assert property (p_tx_status) else $error("status bit wrong");

   property p_tx_hold;
      @(posedge pclk) disable iff (!presetn)
      frame_done && stamp_enable && stamp_request |=> hold_set && hold_value == $past(timer_value);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("hold not loaded");

   property p_tx_nohold;
      @(posedge pclk) disable iff (!presetn)
      frame_done && !stamp_request |=> !hold_set && $stable(hold_value);
   endproperty
   a_tx_nohold: assert property (p_tx_nohold) else $error("hold disturbed");

   property p_tx_seq;
      @(posedge pclk) disable iff (!presetn)
      frame_done && stamp_enable |=> stamp_sequence == SEQ_W'($past(stamp_sequence) + 1'b1);
   endproperty
   a_tx_seq: assert property (p_tx_seq) else $error("sequence not advanced");
endmodule // eth_ptp_tx_stamp
`default_nettype wire

// ---- ptp_client_model.sv ----
// Transmit client and receive DMA model facing the time-stamping block
`timescale 1ns/1ps
`default_nettype none
module ptp_client_model
   import eth_ptp_pkg::*;
(
   input  wire logic                           pclk,
   input  wire logic [eth_ptp_pkg::DATA_W-1:0] rx_stamp_value,
   input  wire logic                           rx_desc_stamp_write,
   output logic                                tx_frame_done,
   output logic                                tx_stamp_request,
   output logic      [eth_ptp_pkg::STAT_W-2:0] tx_frame_status,
   output logic                                rx_sfd_detect,
   output logic                                rx_frame_end
);
   logic [31:0] desc_q[$];
   initial begin
      tx_frame_done = 1'b0;
      tx_stamp_request = 1'b0;
      tx_frame_status = 5'h00;
      rx_sfd_detect = 1'b0;
      rx_frame_end = 1'b0;
   end
   // Descriptor copy of each latched receive stamp
   always @(posedge pclk) begin
      if (rx_desc_stamp_write === 1'b1) begin
         desc_q.push_back(rx_stamp_value);
      end
   end
   // Qualifiers scrambled between frames, so stale values cannot pass
   task automatic tx(input logic req, input logic [4:0] st, output time ts);
      @(posedge pclk);
      tx_frame_done    <= 1'b1;
      tx_stamp_request <= req;
      tx_frame_status  <= st;
      @(posedge pclk);
      ts = $time;
      tx_frame_done    <= 1'b0;
      tx_stamp_request <= ~req;
      tx_frame_status  <= ~st;
   endtask
   task automatic rx(input logic sfd, input int gap, output time ts);
      @(posedge pclk);
      rx_sfd_detect <= sfd;
      @(posedge pclk);
      ts = $time;
      rx_sfd_detect <= 1'b0;
      repeat (gap) @(posedge pclk);
      rx_frame_end <= 1'b1;
      @(posedge pclk);
      rx_frame_end <= 1'b0;
   endtask
endmodule // ptp_client_model
`default_nettype wire

// ---- test_eth_mac_ptp_timestamp.sv ----
// Self-checking bench for the MAC time-stamping block
`timescale 1ns/1ps
`default_nettype none
module test_eth_mac_ptp_timestamp;
   import eth_ptp_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mac_event_set, tx_stamp_value, rx_stamp_value;
   logic [3:0]  tx_stamp_sequence;
   logic [5:0]  tx_stamp_status;
   logic [4:0]  tx_frame_status;
   logic        tx_frame_done, tx_stamp_request, tx_stamp_valid;
   logic        rx_sfd_detect, rx_frame_end, rx_desc_stamp_write;
   logic [41:0] got_q[$];
   time         tt[$];
   logic        rq[$];
   logic [4:0]  st[$];
   int          error_cnt, samples_checked;

   eth_mac_ptp_timestamp eth_mac_ptp_timestamp_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_frame_done(tx_frame_done),
      .tx_stamp_request(tx_stamp_request), .tx_frame_status(tx_frame_status),
      .tx_stamp_value(tx_stamp_value), .tx_stamp_sequence(tx_stamp_sequence),
      .tx_stamp_status(tx_stamp_status), .tx_stamp_valid(tx_stamp_valid),
      .rx_sfd_detect(rx_sfd_detect), .rx_frame_end(rx_frame_end),
      .rx_stamp_value(rx_stamp_value), .rx_desc_stamp_write(rx_desc_stamp_write),
      .mac_event_set(mac_event_set), .irq(irq));
   ptp_client_model ptp_client_model_i (.pclk(pclk), .rx_stamp_value(rx_stamp_value),
      .rx_desc_stamp_write(rx_desc_stamp_write), .tx_frame_done(tx_frame_done),
      .tx_stamp_request(tx_stamp_request), .tx_frame_status(tx_frame_status),
      .rx_sfd_detect(rx_sfd_detect), .rx_frame_end(rx_frame_end));

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      if (tx_stamp_valid === 1'b1) begin
         got_q.push_back({tx_stamp_status, tx_stamp_sequence, tx_stamp_value});
      end
   end

   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         error_cnt++;
         finish_test();
      end else begin
         r = prdata;
         e = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
      chk({31'h0, e}, 32'h0000_0000);
   endtask

   initial begin
      logic [31:0] v, vb, hold_e, r;
      logic [41:0] g;
      logic        e;
      int          i;
      time         t;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, mac_event_set} = '0;
      error_cnt = 0;
      samples_checked = 0;
      vb = 32'h0000_0000;
      hold_e = 32'h0000_0000;
      v = $urandom(93444);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < N_RW; i++) begin
         v = $urandom();
         rd(RW_OFS[i], RW_RESET);
         wr(RW_OFS[i], v);
         rd(RW_OFS[i], v);
      end
      rd(OFS_EVENT_MASK, 32'h0000_0000);
      rd(OFS_ETH_CONTROL, CONTROL_RESET);
      wr(OFS_RX_FIFO_BOUND, 32'hffff_ffff);
      rd(OFS_RX_FIFO_BOUND, RX_FIFO_BOUND_VALUE);
      apb(1'b0, 12'h200, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      // Stamping still off: frames must leave no trace
      ptp_client_model_i.tx(1'b1, 5'h1f, t);
      ptp_client_model_i.rx(1'b1, 3, t);
      repeat (4) @(posedge pclk);
      chk(32'(got_q.size()), 32'h0000_0000);
      chk(32'(ptp_client_model_i.desc_q.size()), 32'h0000_0000);
      rd(OFS_EVENT_FLAGS, 32'h0000_0000);
      rd(OFS_TX_STAMP_HOLD, 32'h0000_0000);
      rd(OFS_TIMER_VALUE, 32'h0000_0000);
      rd(OFS_TIMER_PERIOD, TIMER_PERIOD_RESET);
      wr(OFS_ETH_CONTROL, 32'h1 << CTRL_STAMP_EN_BIT);
      wr(OFS_EVENT_MASK, 32'h1 << FLAG_STAMP_READY_BIT);
      rd(OFS_EVENT_MASK, 32'h1 << FLAG_STAMP_READY_BIT);
      for (i = 0; i < 17; i++) begin
         rq.push_back(i == 0 || $urandom_range(1) == 1);
         st.push_back(5'($urandom()));
         ptp_client_model_i.tx(rq[i], st[i], t);
         tt.push_back(t);
      end
      repeat (4) @(posedge pclk);
      chk(32'(got_q.size()), 32'd17);
      // Timer steps 20 per 20 ns cycle, so stamp gaps equal time gaps
      for (i = 0; i < 17 && got_q.size() > 0; i++) begin
         g = got_q.pop_front();
         if (i == 0) begin
            vb = g[31:0];
         end
         v = vb + 32'(tt[i] - tt[0]);
         if (rq[i]) begin
            hold_e = v;
         end
         chk(g[31:0], v);
         chk({28'h0, g[35:32]}, 32'((i + 1) % 16));
         chk({26'h0, g[41:36]}, {26'h0, rq[i], st[i]});
      end
      rd(OFS_EVENT_FLAGS, 32'h1 << FLAG_STAMP_READY_BIT);
      rd(OFS_TX_STAMP_HOLD, hold_e);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(OFS_EVENT_FLAGS, 32'h0000_0000);
      rd(OFS_EVENT_FLAGS, 32'h1 << FLAG_STAMP_READY_BIT);
      wr(OFS_EVENT_FLAGS, 32'h1 << FLAG_STAMP_READY_BIT);
      rd(OFS_EVENT_FLAGS, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      ptp_client_model_i.tx(1'b0, 5'h0a, t);
      repeat (4) @(posedge pclk);
      g = got_q.pop_front();
      chk({26'h0, g[41:36]}, 32'h0000_000a);
      chk({28'h0, g[35:32]}, 32'h0000_0002);
      chk(g[31:0], vb + 32'(t - tt[0]));
      rd(OFS_EVENT_FLAGS, 32'h0000_0000);
      rd(OFS_TX_STAMP_HOLD, hold_e);
      // Middle frame has no delimiter and must not reach a descriptor
      for (i = 0; i < 3; i++) begin
         ptp_client_model_i.rx(i != 1, 1 + i * 5, t);
         repeat (3) @(posedge pclk);
         if (i != 1) begin
            chk(ptp_client_model_i.desc_q.pop_front(), vb + 32'(t - tt[0]));
         end
      end
      chk(32'(ptp_client_model_i.desc_q.size()), 32'h0000_0000);
      // Second reset restarts the timer so a short period wraps early
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_EVENT_FLAGS, 32'h0000_0000);
      @(posedge pclk);
      mac_event_set <= 32'h0000_0008;
      @(posedge pclk);
      mac_event_set <= 32'h0000_0000;
      wr(OFS_TIMER_PERIOD, 32'h0000_0190);
      rd(OFS_TIMER_PERIOD, 32'h0000_0190);
      wr(OFS_EVENT_MASK, 32'h1 << FLAG_TIMER_EVENT_BIT);
      wr(OFS_ETH_CONTROL, 32'h1 << CTRL_STAMP_EN_BIT);
      repeat (25) @(posedge pclk);
      rd(OFS_EVENT_FLAGS, (32'h1 << FLAG_TIMER_EVENT_BIT) | 32'h0000_0008);
      chk({31'h0, irq}, 32'h0000_0001);
      finish_test();
   end
endmodule // test_eth_mac_ptp_timestamp
`default_nettype wire
